// ---- fp_port_consts.svh ----
// constants for the shared floppy/printer connector block
// Behaviour
// - connector carries floppy or printer, never both
// - floppy function is the reset default
// - floppy serves drives from 360kB to 2.88MB
// - printer modes compat, bidir, SPP, EPP, ECP
// - strobe output, two-way in ECP/EPP
// - initialize output, two-way in ECP/EPP
// - select-in output, two-way in ECP/EPP
// - active-low line advance request to printer
// - eight data bits, five sharing pins with drive sense inputs
// - density select low slow, high fast
// - side pin 0 means side one
// - direction set before step, 0 inward
// - one low step pulse per track
// - raw read data in, encoded write out
// - write gate only while writing
// - drive one select and motor outputs
`ifndef FP_PORT_CONSTS_SVH
`define FP_PORT_CONSTS_SVH

`define PIN_COUNT 17
`define PIN_STROBE 0
`define PIN_FEED_DENS 1
`define PIN_D0_INDEX 2
`define PIN_ERR_SIDE 3
`define PIN_D1_TRACK 4
`define PIN_INIT_DIR 5
`define PIN_D2_LOCK 6
`define PIN_CHOOSE_STEP 7
`define PIN_D3_RDATA 8
`define PIN_D4_SWAP 9
`define PIN_D5 10
`define PIN_D6 11
`define PIN_D7 12
`define PIN_ACK_DRIVE 13
`define PIN_BUSY_MOTOR 14
`define PIN_PAPER_WDATA 15
`define PIN_SELECT_WRITE_CURRENT_ON 16

`define REG_CONFIG 8'h00
`define REG_PDATA 8'h04
`define REG_PCTRL 8'h08
`define REG_PSTAT 8'h0c
`define REG_FSTAT 8'h10

`define CFG_FUNC 0
`define CFG_MODE_LO 1
`define CFG_DATA_IN 4
`define CFG_CTL_RELEASE 5
`define PCTRL_FEED 0
`define PCTRL_INIT 1
`define PCTRL_CHOOSE 2
`define PCTRL_RESET 3'h3
`define PSTAT_ACK_SEEN 6
`define PSTAT_REFUSED 7

`define CLK_MHZ 125
`define CYC_UP(ns) (((ns) * `CLK_MHZ + 999) / 1000)
`define PP_SETUP_NS 500
`define PP_STROBE_NS 500
`define PP_HOLD_NS 500
`define PP_ACK_WAIT_NS 100000
`define FD_DIR_SETUP_NS 1000
`define FD_STEP_NS 3000
`define FD_STEP_RECOVER_NS 1000
`define PP_SETUP_CYC `CYC_UP(`PP_SETUP_NS)
`define PP_STROBE_CYC `CYC_UP(`PP_STROBE_NS)
`define PP_HOLD_CYC `CYC_UP(`PP_HOLD_NS)
`define PP_ACK_WAIT_CYC `CYC_UP(`PP_ACK_WAIT_NS)
`define FD_DIR_SETUP_CYC `CYC_UP(`FD_DIR_SETUP_NS)
`define FD_STEP_CYC `CYC_UP(`FD_STEP_NS)
`define FD_STEP_RECOVER_CYC `CYC_UP(`FD_STEP_RECOVER_NS)

`endif

// ---- fp_port_pkg.sv ----
// types shared by the floppy/printer connector block
package fp_port_pkg;
  typedef enum logic [0:0] {func_floppy = 1'b0, func_printer = 1'b1} func_e;
  typedef enum logic [2:0]
  {
    mode_compat = 3'h0,
    mode_bidir = 3'h1,
    mode_spp = 3'h2,
    mode_epp = 3'h3,
    mode_ecp = 3'h4
  } pp_mode_e;
  typedef enum logic [2:0]
  {
    pp_idle = 3'h0,
    pp_wait_busy = 3'h1,
    pp_setup = 3'h2,
    pp_strobe = 3'h3,
    pp_hold = 3'h4,
    pp_wait_ack = 3'h5
  } pp_state_e;
  typedef enum logic [1:0]
  {
    st_idle = 2'h0,
    st_dir_setup = 2'h1,
    st_pulse = 2'h2,
    st_recover = 2'h3
  } step_state_e;
  typedef enum logic [1:0]
  {
    rate_250k = 2'h0,
    rate_300k = 2'h1,
    rate_500k = 2'h2,
    rate_1m = 2'h3
  } rate_e;
endpackage

// ---- pin_sync.sv ----
// two-flop synchroniser for a group of connector inputs
`timescale 1ns/1ns
module pin_sync #(
  parameter int WIDTH = 17
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] first_stage;

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      first_stage <= '0;
      o_sync <= '0;
    end
    else
    begin
      first_stage <= i_async;
      o_sync <= first_stage;
    end
  end
endmodule

// ---- floppy_printer_shared_port.sv ----
// shared connector logic: floppy drive port or printer port on one set of pins
//
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ns
`include "fp_port_consts.svh"
module floppy_printer_shared_port #(
  parameter int ACK_WAIT_CYC = `PP_ACK_WAIT_CYC
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic [1:0] i_fdc_rate,
  input wire logic i_fdc_side,
  input wire logic i_fdc_step_req,
  input wire logic i_fdc_step_outward,
  output logic o_fdc_step_busy,
  input wire logic i_fdc_write,
  input wire logic i_fdc_wdata,
  input wire logic i_fdc_drive_one_choose,
  input wire logic i_fdc_drive_one_spindle_on,
  output logic o_fdc_index,
  output logic o_fdc_outer_track_sense,
  output logic o_fdc_media_lock_sense,
  output logic o_fdc_rdata,
  output logic o_fdc_media_swapped_sense,
  output logic o_printer_selected,
  input wire logic [`PIN_COUNT-1:0] i_pin,
  output logic [`PIN_COUNT-1:0] o_pin,
  output logic [`PIN_COUNT-1:0] o_pin_oe_n
);
  localparam int CNT_W = 16;

  function automatic int data_pin(input int bit_idx);
    case (bit_idx)
      0: data_pin = `PIN_D0_INDEX;
      1: data_pin = `PIN_D1_TRACK;
      2: data_pin = `PIN_D2_LOCK;
      3: data_pin = `PIN_D3_RDATA;
      4: data_pin = `PIN_D4_SWAP;
      5: data_pin = `PIN_D5;
      6: data_pin = `PIN_D6;
      default: data_pin = `PIN_D7;
    endcase
  endfunction

  logic [`PIN_COUNT-1:0] pin_s;
  fp_port_pkg::func_e func;
  fp_port_pkg::pp_mode_e mode;
  logic data_in;
  logic ctl_release;
  logic [2:0] pctrl;
  logic [7:0] pdata;
  logic ack_seen;
  logic refused;
  logic ack_prev;
  logic ack_fall;
  fp_port_pkg::pp_state_e pp_state;
  logic [CNT_W-1:0] pp_cnt;
  fp_port_pkg::step_state_e st_state;
  logic [CNT_W-1:0] st_cnt;
  logic step_outward;
  logic [7:0] pin_data_in;
  logic is_printer;
  logic is_floppy;
  logic two_way_ctl;
  logic drive_ctl;
  logic drive_data;
  logic data_write;
  logic launch;
  logic [`PIN_COUNT-1:0] next_pin;
  logic [`PIN_COUNT-1:0] next_oe_n;

  // every pin input crosses into the clock domain before use
  pin_sync #(
    .WIDTH(`PIN_COUNT)
  ) u_pin_sync (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_async(i_pin),
    .o_sync(pin_s)
  );

  assign is_printer = (func == fp_port_pkg::func_printer);
  assign is_floppy = (func == fp_port_pkg::func_floppy);
  assign two_way_ctl = (mode == fp_port_pkg::mode_epp) || (mode == fp_port_pkg::mode_ecp);
  // control lines are released only in the enhanced modes
  assign drive_ctl = !(two_way_ctl && ctl_release);
  // output-only compat mode can never turn the data bus round
  assign drive_data = (mode == fp_port_pkg::mode_compat) || !data_in;
  assign data_write = i_wr && (i_addr == `REG_PDATA);
  assign launch = data_write && is_printer && drive_data && (pp_state == fp_port_pkg::pp_idle);
  assign o_printer_selected = is_printer;
  assign o_fdc_step_busy = (st_state != fp_port_pkg::st_idle);

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_data_in
      assign pin_data_in[gi] = pin_s[data_pin(gi)];
    end
  endgenerate

  // configuration; floppy is the reset function
  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      func <= fp_port_pkg::func_floppy;
      mode <= fp_port_pkg::mode_compat;
      data_in <= 1'b0;
      ctl_release <= 1'b0;
    end
    else if (i_wr && (i_addr == `REG_CONFIG))
    begin
      func <= fp_port_pkg::func_e'(i_wdata[`CFG_FUNC]);
      // an unknown mode code falls back to compat
      case (i_wdata[`CFG_MODE_LO +: 3])
        3'h0: mode <= fp_port_pkg::mode_compat;
        3'h1: mode <= fp_port_pkg::mode_bidir;
        3'h2: mode <= fp_port_pkg::mode_spp;
        3'h3: mode <= fp_port_pkg::mode_epp;
        3'h4: mode <= fp_port_pkg::mode_ecp;
        default: mode <= fp_port_pkg::mode_compat;
      endcase
      data_in <= i_wdata[`CFG_DATA_IN];
      ctl_release <= i_wdata[`CFG_CTL_RELEASE];
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      pctrl <= `PCTRL_RESET;
    end
    else if (i_wr && (i_addr == `REG_PCTRL))
    begin
      pctrl <= i_wdata[2:0];
    end
  end

  // data byte is held steady for the whole strobe cycle
  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      pdata <= 8'h00;
    end
    else if (launch)
    begin
      pdata <= i_wdata[7:0];
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      ack_prev <= 1'b1;
    end
    else
    begin
      ack_prev <= pin_s[`PIN_ACK_DRIVE];
    end
  end
  assign ack_fall = is_printer && ack_prev && !pin_s[`PIN_ACK_DRIVE];

  // sticky flags: write one to clear, a new event in the same cycle wins
  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      ack_seen <= 1'b0;
      refused <= 1'b0;
    end
    else
    begin
      if (ack_fall)
        ack_seen <= 1'b1;
      else if (i_wr && (i_addr == `REG_PSTAT) && i_wdata[`PSTAT_ACK_SEEN])
        ack_seen <= 1'b0;
      if (data_write && !launch)
        refused <= 1'b1;
      else if (i_wr && (i_addr == `REG_PSTAT) && i_wdata[`PSTAT_REFUSED])
        refused <= 1'b0;
    end
  end

  // printer byte handshake; leaving printer function aborts it
  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      pp_state <= fp_port_pkg::pp_idle;
      pp_cnt <= '0;
    end
    else if (!is_printer)
    begin
      pp_state <= fp_port_pkg::pp_idle;
      pp_cnt <= '0;
    end
    else
    begin
      unique case (pp_state)
        fp_port_pkg::pp_idle:
        begin
          if (launch)
            pp_state <= fp_port_pkg::pp_wait_busy;
        end
        fp_port_pkg::pp_wait_busy:
        begin
          // byte is not strobed while the printer says busy
          if (!pin_s[`PIN_BUSY_MOTOR])
          begin
            pp_state <= fp_port_pkg::pp_setup;
            pp_cnt <= CNT_W'(`PP_SETUP_CYC - 1);
          end
        end
        fp_port_pkg::pp_setup:
        begin
          if (pp_cnt == '0)
          begin
            pp_state <= fp_port_pkg::pp_strobe;
            pp_cnt <= CNT_W'(`PP_STROBE_CYC - 1);
          end
          else
            pp_cnt <= pp_cnt - 1'b1;
        end
        fp_port_pkg::pp_strobe:
        begin
          if (pp_cnt == '0)
          begin
            pp_state <= fp_port_pkg::pp_hold;
            pp_cnt <= CNT_W'(`PP_HOLD_CYC - 1);
          end
          else
            pp_cnt <= pp_cnt - 1'b1;
        end
        fp_port_pkg::pp_hold:
        begin
          if (pp_cnt == '0)
          begin
            pp_state <= fp_port_pkg::pp_wait_ack;
            pp_cnt <= CNT_W'(ACK_WAIT_CYC - 1);
          end
          else
            pp_cnt <= pp_cnt - 1'b1;
        end
        fp_port_pkg::pp_wait_ack:
        begin
          // a silent printer must not hang the port, so the wait is bounded
          if (ack_fall || (pp_cnt == '0))
            pp_state <= fp_port_pkg::pp_idle;
          else
            pp_cnt <= pp_cnt - 1'b1;
        end
        default:
          pp_state <= fp_port_pkg::pp_idle;
      endcase
    end
  end

  // head step: direction latched, settled, then one low pulse per track
  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      st_state <= fp_port_pkg::st_idle;
      st_cnt <= '0;
      step_outward <= 1'b0;
    end
    else if (!is_floppy)
    begin
      st_state <= fp_port_pkg::st_idle;
      st_cnt <= '0;
    end
    else
    begin
      unique case (st_state)
        fp_port_pkg::st_idle:
        begin
          if (i_fdc_step_req)
          begin
            step_outward <= i_fdc_step_outward;
            st_state <= fp_port_pkg::st_dir_setup;
            st_cnt <= CNT_W'(`FD_DIR_SETUP_CYC - 1);
          end
        end
        fp_port_pkg::st_dir_setup:
        begin
          if (st_cnt == '0)
          begin
            st_state <= fp_port_pkg::st_pulse;
            st_cnt <= CNT_W'(`FD_STEP_CYC - 1);
          end
          else
            st_cnt <= st_cnt - 1'b1;
        end
        fp_port_pkg::st_pulse:
        begin
          if (st_cnt == '0)
          begin
            st_state <= fp_port_pkg::st_recover;
            st_cnt <= CNT_W'(`FD_STEP_RECOVER_CYC - 1);
          end
          else
            st_cnt <= st_cnt - 1'b1;
        end
        fp_port_pkg::st_recover:
        begin
          if (st_cnt == '0)
            st_state <= fp_port_pkg::st_idle;
          else
            st_cnt <= st_cnt - 1'b1;
        end
      endcase
    end
  end

  // pin mux: only the selected function reaches the connector
  always_comb
  begin
    next_pin = '0;
    next_oe_n = '1;
    if (is_printer)
    begin
      next_pin[`PIN_STROBE] = (pp_state != fp_port_pkg::pp_strobe);
      next_oe_n[`PIN_STROBE] = !drive_ctl;
      next_pin[`PIN_FEED_DENS] = pctrl[`PCTRL_FEED];
      next_oe_n[`PIN_FEED_DENS] = 1'b0;
      next_pin[`PIN_INIT_DIR] = pctrl[`PCTRL_INIT];
      next_oe_n[`PIN_INIT_DIR] = !drive_ctl;
      next_pin[`PIN_CHOOSE_STEP] = pctrl[`PCTRL_CHOOSE];
      next_oe_n[`PIN_CHOOSE_STEP] = !drive_ctl;
      for (int b = 0; b < 8; b++)
      begin
        next_pin[data_pin(b)] = pdata[b];
        next_oe_n[data_pin(b)] = !drive_data;
      end
    end
    else
    begin
      // 500k and 1M both count as the fast rate
      next_pin[`PIN_FEED_DENS] = i_fdc_rate[1];
      next_oe_n[`PIN_FEED_DENS] = 1'b0;
      next_pin[`PIN_ERR_SIDE] = !i_fdc_side;
      next_oe_n[`PIN_ERR_SIDE] = 1'b0;
      next_pin[`PIN_INIT_DIR] = step_outward;
      next_oe_n[`PIN_INIT_DIR] = 1'b0;
      next_pin[`PIN_CHOOSE_STEP] = (st_state != fp_port_pkg::st_pulse);
      next_oe_n[`PIN_CHOOSE_STEP] = 1'b0;
      next_pin[`PIN_ACK_DRIVE] = i_fdc_drive_one_choose;
      next_oe_n[`PIN_ACK_DRIVE] = 1'b0;
      next_pin[`PIN_BUSY_MOTOR] = i_fdc_drive_one_spindle_on;
      next_oe_n[`PIN_BUSY_MOTOR] = 1'b0;
      // write data and gate only move while a write is in progress
      next_pin[`PIN_PAPER_WDATA] = i_fdc_write && i_fdc_wdata;
      next_oe_n[`PIN_PAPER_WDATA] = 1'b0;
      next_pin[`PIN_SELECT_WRITE_CURRENT_ON] = i_fdc_write;
      next_oe_n[`PIN_SELECT_WRITE_CURRENT_ON] = 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_pin <= '0;
      o_pin_oe_n <= '1;
    end
    else
    begin
      o_pin <= next_pin;
      o_pin_oe_n <= next_oe_n;
    end
  end

  // drive sense lines reach the controller only in floppy function
  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_fdc_index <= 1'b0;
      o_fdc_outer_track_sense <= 1'b0;
      o_fdc_media_lock_sense <= 1'b0;
      o_fdc_rdata <= 1'b0;
      o_fdc_media_swapped_sense <= 1'b0;
    end
    else
    begin
      o_fdc_index <= is_floppy && pin_s[`PIN_D0_INDEX];
      o_fdc_outer_track_sense <= is_floppy && pin_s[`PIN_D1_TRACK];
      o_fdc_media_lock_sense <= is_floppy && pin_s[`PIN_D2_LOCK];
      o_fdc_rdata <= is_floppy && pin_s[`PIN_D3_RDATA];
      o_fdc_media_swapped_sense <= is_floppy && pin_s[`PIN_D4_SWAP];
    end
  end

  // register read port, data one cycle after the strobe, zero otherwise
  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_rdata <= 32'h0;
    end
    else if (i_rd)
    begin
      case (i_addr)
        `REG_CONFIG: o_rdata <= {26'h0, ctl_release, data_in, mode, func};
        `REG_PDATA: o_rdata <= {24'h0, drive_data ? pdata : pin_data_in};
        `REG_PCTRL: o_rdata <= {29'h0, pctrl};
        `REG_PSTAT: o_rdata <= {20'h0, pin_s[`PIN_CHOOSE_STEP], pin_s[`PIN_INIT_DIR],
                                pin_s[`PIN_FEED_DENS], pin_s[`PIN_STROBE], refused, ack_seen,
                                (pp_state != fp_port_pkg::pp_idle),
                                pin_s[`PIN_SELECT_WRITE_CURRENT_ON],
                                pin_s[`PIN_PAPER_WDATA],
                                pin_s[`PIN_ERR_SIDE],
                                pin_s[`PIN_ACK_DRIVE], pin_s[`PIN_BUSY_MOTOR]};
        `REG_FSTAT: o_rdata <= {26'h0, o_fdc_step_busy, pin_s[`PIN_D4_SWAP],
                                pin_s[`PIN_D3_RDATA], pin_s[`PIN_D2_LOCK],
                                pin_s[`PIN_D1_TRACK], pin_s[`PIN_D0_INDEX]};
        default: o_rdata <= 32'h0;
      endcase
    end
    else
    begin
      o_rdata <= 32'h0;
    end
  end
endmodule

// ---- floppy_printer_shared_port_monitor.sv ----
// concurrent checks on the shared floppy/printer connector ports
`timescale 1ns/1ns
module floppy_printer_shared_port_monitor (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic [7:0] i_addr,
  input wire logic i_wr,
  input wire logic [1:0] i_fdc_rate,
  input wire logic i_fdc_side,
  input wire logic i_fdc_step_req,
  input wire logic i_fdc_step_outward,
  input wire logic i_fdc_write,
  input wire logic i_fdc_wdata,
  input wire logic i_fdc_drive_one_choose,
  input wire logic i_fdc_drive_one_spindle_on,
  input wire logic o_fdc_step_busy,
  input wire logic o_fdc_index,
  input wire logic o_printer_selected,
  input wire logic [16:0] o_pin,
  input wire logic [16:0] o_pin_oe_n
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  // floppy pins only compared once the first registered value has landed
  property p_func_stays;
    !o_printer_selected && !(i_wr && i_addr == 8'h00) |=> !o_printer_selected;
  endproperty
  a_func_stays: assert property (p_func_stays) else $error("function left floppy");
  property p_pins_off;
    $past(!o_printer_selected) |-> (o_pin_oe_n & 17'h01f55) == 17'h01f55;
  endproperty
  a_pins_off: assert property (p_pins_off) else $error("printer pin driven");
  property p_density;
    $past(i_nrst) && $past(!o_printer_selected) |-> o_pin[1] == $past(i_fdc_rate[1]);
  endproperty
  a_density: assert property (p_density) else $error("density pin wrong");
  property p_side;
    $past(i_nrst) && $past(!o_printer_selected) |-> o_pin[3] == !$past(i_fdc_side);
  endproperty
  a_side: assert property (p_side) else $error("side pin wrong");
  property p_write_current_on;
    $past(i_nrst) && $past(!o_printer_selected) |->
      {o_pin[16], o_pin[15]} == {$past(i_fdc_write), $past(i_fdc_write && i_fdc_wdata)};
  endproperty
  a_write_current_on: assert property (p_write_current_on) else $error("write gate or data wrong");
  property p_drive_one;
    $past(i_nrst) && $past(!o_printer_selected) |->
      {o_pin[13], o_pin[14]} == $past({i_fdc_drive_one_choose, i_fdc_drive_one_spindle_on});
  endproperty
  a_drive_one: assert property (p_drive_one) else $error("drive one pins wrong");
  property p_sense_off;
    o_printer_selected && $past(o_printer_selected) |-> !o_fdc_index;
  endproperty
  a_sense_off: assert property (p_sense_off) else $error("sense leaked");
  property p_step_dir;
    i_fdc_step_req && !o_fdc_step_busy && !o_printer_selected |=> o_fdc_step_busy ##1
      o_pin[5] == $past(i_fdc_step_outward, 2) ##0 (o_pin[7] && o_fdc_step_busy)[*8];
  endproperty
  a_step_dir: assert property (p_step_dir) else $error("direction not set first");
  property p_step_low;
    $past(i_nrst) && $past(!o_printer_selected) && !o_pin[7] |-> $past(o_fdc_step_busy);
  endproperty
  a_step_low: assert property (p_step_low) else $error("stray step pulse");
endmodule
bind floppy_printer_shared_port floppy_printer_shared_port_monitor mon (.i_clock, .i_nrst,
  .i_addr, .i_wr, .i_fdc_rate, .i_fdc_side, .i_fdc_step_req, .i_fdc_step_outward,
  .i_fdc_write, .i_fdc_wdata, .i_fdc_drive_one_choose, .i_fdc_drive_one_spindle_on,
  .o_fdc_step_busy, .o_fdc_index, .o_printer_selected, .o_pin, .o_pin_oe_n);

// ---- shared_port_far_end.sv ----
// far-end model: a printer or floppy drive one on the shared connector
`timescale 1ns/1ns
module shared_port_far_end (
  input wire logic i_clock,
  input wire logic i_printer,
  input wire logic i_busy,
  input wire logic [2:0] i_status,
  input wire logic [4:0] i_sense,
  input wire logic [16:0] i_drv,
  input wire logic [16:0] i_drv_oe_n,
  output logic [16:0] o_wire
);
  logic [16:0] far;
  logic [16:0] far_en;
  logic tog = 1'b0;
  logic ack_n = 1'b1;
  logic taking = 1'b0;
  logic strobe_q = 1'b1;
  logic [6:0] cnt = 7'h00;
  always_comb
  begin
    far = 17'h00000;
    far_en = i_printer ? 17'h1e008 : 17'h00354;
    far[3] = i_status[0];
    far[13] = ack_n;
    far[14] = i_busy | taking;
    far[15] = i_status[1];
    far[16] = i_status[2];
    {far[9], far[8], far[6], far[4], far[2]} = i_sense;
  end
  // undriven pins toggle so a stale value can never pass for a driven one
  assign o_wire = (~i_drv_oe_n & i_drv) | (i_drv_oe_n & far_en & far) |
    (i_drv_oe_n & ~far_en & ({17{tog}} ^ 17'h0aaaa));
  always @(posedge i_clock)
  begin
    tog <= ~tog;
    strobe_q <= o_wire[0];
    if (i_printer && !i_drv_oe_n[0] && !strobe_q && o_wire[0])
    begin
      taking <= 1'b1;
      cnt <= 7'h00;
    end
    else if (taking)
    begin
      cnt <= cnt + 7'h01;
      ack_n <= !(cnt >= 7'h50 && cnt < 7'h54);
      taking <= cnt != 7'h56;
    end
  end
endmodule

// ---- floppy_printer_shared_port_bench.sv ----
// self-checking bench for the shared floppy/printer connector
`timescale 1ns/1ns
module floppy_printer_shared_port_bench;
  logic i_clock = 1'b0;
  logic i_nrst = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [1:0] i_fdc_rate = 2'h0;
  logic i_fdc_side = 1'b0;
  logic i_fdc_step_req = 1'b0;
  logic i_fdc_step_outward = 1'b0;
  logic i_fdc_write = 1'b0;
  logic i_fdc_wdata = 1'b0;
  logic choose = 1'b0;
  logic spin = 1'b0;
  logic printer = 1'b0;
  logic busy = 1'b0;
  logic [2:0] status = 3'h6;
  logic [4:0] sense = 5'h00;
  logic [31:0] o_rdata;
  logic [31:0] rv;
  logic o_fdc_step_busy, o_index, o_track, o_lock, o_rdat, o_swap, o_printer_selected;
  logic [16:0] pin_wire, o_pin, o_pin_oe_n;
  int mismatches = 0;
  int checks_done = 0;
  int len;
  floppy_printer_shared_port #(.ACK_WAIT_CYC(40)) dut (.i_clock, .i_nrst, .i_addr, .i_wdata,
    .i_wr, .i_rd, .o_rdata, .i_fdc_rate, .i_fdc_side, .i_fdc_step_req, .i_fdc_step_outward,
    .o_fdc_step_busy, .i_fdc_write, .i_fdc_wdata, .i_fdc_drive_one_choose(choose),
    .i_fdc_drive_one_spindle_on(spin), .o_fdc_index(o_index), .o_fdc_outer_track_sense(o_track),
    .o_fdc_media_lock_sense(o_lock), .o_fdc_rdata(o_rdat), .o_fdc_media_swapped_sense(o_swap),
    .o_printer_selected, .i_pin(pin_wire), .o_pin, .o_pin_oe_n);
  shared_port_far_end far (.i_clock, .i_printer(printer), .i_busy(busy), .i_status(status),
    .i_sense(sense), .i_drv(o_pin), .i_drv_oe_n(o_pin_oe_n), .o_wire(pin_wire));
  initial
    forever #4 i_clock = ~i_clock;
  task automatic conclude;
    if (mismatches == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_clock);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1;
    rv = o_rdata;
  endtask
  // waits on a pin, or on step busy as index 17
  task automatic await(input int idx, input logic v);
    logic [17:0] seen;
    seen = {o_fdc_step_busy, o_pin};
    for (len = 0; seen[idx] !== v; len++)
    begin
      @(posedge i_clock);
      #1;
      seen = {o_fdc_step_busy, o_pin};
      if (len == 1000)
      begin
        mismatches++;
        $display("[ERR] %0t wait ran out", $time);
        conclude();
      end
    end
  endtask
  task automatic step(input logic outward);
    @(posedge i_clock);
    i_fdc_step_req <= 1'b1;
    i_fdc_step_outward <= outward;
    @(posedge i_clock);
    i_fdc_step_req <= 1'b0;
    repeat (2) @(posedge i_clock);
    #1;
    check(o_pin[5], outward);
  endtask
  initial
  begin
    repeat (3) @(posedge i_clock);
    check(o_pin_oe_n, 17'h1ffff);
    i_nrst <= 1'b1;
    repeat (3) @(posedge i_clock);
    #1;
    check(o_pin_oe_n, 17'h01f55);
    rd(8'h00);
    check(rv, 32'h0);
    rd(8'h40);
    check(rv, 32'h0);
    for (int r = 0; r < 4; r++)
    begin
      @(posedge i_clock);
      i_fdc_rate <= r[1:0];
      i_fdc_side <= r[0];
      i_fdc_write <= r[1];
      i_fdc_wdata <= 1'b1;
      choose <= r[0];
      spin <= !r[0];
      sense <= 5'h01 << r;
      repeat (5) @(posedge i_clock);
      #1;
      check(o_pin[1], r[1]);
      check(o_pin[3], !r[0]);
      check({o_pin[16], o_pin[15]}, {2{r[1]}});
      check({o_pin[13], o_pin[14]}, {r[0], !r[0]});
      check({o_swap, o_rdat, o_lock, o_track, o_index}, 5'h01 << r);
    end
    rd(8'h10);
    check(rv, 32'h08);
    step(1'b1);
    await(7, 1'b0);
    await(7, 1'b1);
    check(len, 375);
    // recovery is 125 cycles, the step pin lags the state by one
    await(17, 1'b0);
    check(len, 124);
    step(1'b0);
    // direction settles 125 cycles before the pulse
    await(7, 1'b0);
    check(len, 124);
    await(17, 1'b0);
    check(len, 499);
    sense <= 5'h1f;
    busy <= 1'b1;
    printer <= 1'b1;
    wr(8'h00, 32'h1);
    repeat (4) @(posedge i_clock);
    #1;
    check(o_pin_oe_n, 17'h1e008);
    check(o_printer_selected, 1'b1);
    check({o_swap, o_rdat, o_lock, o_track, o_index}, 5'h00);
    wr(8'h04, 32'ha5);
    repeat (150) @(posedge i_clock);
    #1;
    check(o_pin[0], 1'b1);
    rd(8'h0c);
    check(rv[4:0], 5'h1b);
    busy <= 1'b0;
    await(0, 1'b0);
    check({o_pin[12:8], o_pin[6], o_pin[4], o_pin[2]}, 8'ha5);
    rd(8'h04);
    check(rv, 32'ha5);
    wr(8'h04, 32'h5a);
    repeat (200) @(posedge i_clock);
    rd(8'h0c);
    check(rv[7:6], 2'h3);
    wr(8'h0c, 32'hc0);
    rd(8'h0c);
    check(rv[7:6], 2'h0);
    for (int m = 0; m < 5; m++)
    begin
      wr(8'h00, 32'h21 | (32'(m) << 1));
      rd(8'h00);
      check(rv, 32'h21 | (32'(m) << 1));
      check({o_pin_oe_n[7], o_pin_oe_n[5], o_pin_oe_n[0]}, {3{m > 2}});
    end
    wr(8'h00, 32'h1);
    wr(8'h08, 32'h2);
    repeat (2) @(posedge i_clock);
    #1;
    check(o_pin[1], 1'b0);
    printer <= 1'b0;
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h1);
    rd(8'h0c);
    check(rv[7], 1'b1);
    check(o_pin_oe_n, 17'h01f55);
    conclude();
  end
endmodule
